//--- core/spisel_top.sv
/*
  Serial peripheral port: pin directions, select modes, master clock
  generation and an 8-bit shift path in master and slave roles.
  Assumes pin inputs are asynchronous; the serial clock pin clocks the
  slave engine directly. Configuration is static while enabled.
*/
// Summary of operation
// - Master-out drives as master, listens as slave, MSB first.
// - Master-in listens as master, drives as slave in modes 00 and 01.
// - As master, master-out comes from the shift register MSB.
// - Master-in floats when disabled or as an unselected 4-wire slave.
// - A 3-wire slave always drives master-in: word MSB before the first shift, then its shift MSB.
// - Clock is made only as master; unselected 4-wire slave ignores it.
// - Mode 00 is 3-wire, select unused, slave always selected.
// - Mode 01 select is input; its fall disables the master.
// - Mode 1x drives select with the mode low bit, in master and slave roles.
// - Select pin is unmapped in 3-wire mode, mapped otherwise.
// - Clock rate value sets master clock only; ignored as slave.
// - Master bit rate at most an eighth of system clock, 12.5 MHz.
`default_nettype none

module spisel_top (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_n_in,

  // Configuration
  input  wire logic       port_enable_bit_in,
  input  wire logic       master_mode_in,
  input  wire logic [1:0] select_mode_field_in,
  input  wire logic       clock_polarity_in,
  input  wire logic       clock_phase_select_in,
  input  wire logic [7:0] master_clock_rate_register_in,

  // Master requests
  input  wire logic       master_start_in,
  input  wire logic [7:0] master_tx_data_in,
  output logic [7:0]      master_rx_data_out,
  output logic            master_done_out,
  output logic            master_busy_out,
  output logic            mode_fault_out,
  input  wire logic       mode_fault_clear_in,

  // Slave data
  input  wire logic       slave_tx_load_in,
  input  wire logic [7:0] slave_tx_data_in,
  output logic [7:0]      slave_rx_data_out,
  output logic            slave_rx_valid_out,

  // Pins
  input  wire logic       link_sck_in,
  output logic            sck_out,
  output logic            sck_oe_out,
  input  wire logic       mosi_in,
  output logic            mosi_out,
  output logic            mosi_oe_out,
  input  wire logic       miso_in,
  output logic            miso_out,
  output logic            miso_oe_out,
  input  wire logic       nss_in,
  output logic            nss_out,
  output logic            nss_oe_out,
  output logic            nss_pin_mapped_out
);

  spisel_link_if lnk ();

  // Synchronisers and configuration copies
  logic       nss_s1_q;
  logic       nss_s2_q;
  logic       nss_s3_q;
  logic       miso_s1_q;
  logic       miso_s2_q;
  logic       tgl_s1_q;
  logic       tgl_s2_q;
  logic       tgl_s3_q;
  logic [1:0] mode_q;
  logic       slave_3w_q;
  logic       slave_4w_q;

  // Master path
  spisel_pkg::spisel_mst_state_t state_q;
  logic       master_act_q;
  logic       fault_q;
  logic [8:0] div_q;
  logic [8:0] half_cyc;
  logic [3:0] edge_q;
  logic       sck_q;
  logic [7:0] mtx_q;
  logic [7:0] mrx_q;
  logic [7:0] mrx_data_q;
  logic       mdone_q;
  logic       tick;
  logic       leading;
  logic       nss_fall;

  // Slave path and pin enables
  logic [7:0] stx_q;
  logic [7:0] srx_data_q;
  logic       srx_valid_q;
  logic       miso_oe_q;
  logic       mosi_oe_q;
  logic       nss_out_q;
  logic       nss_oe_q;
  logic       nss_map_q;

  // Two-flop synchronisers for the select and master-in pins and the word toggle, plus a third flop for edges
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      nss_s1_q  <= 1'b1;
      nss_s2_q  <= 1'b1;
      nss_s3_q  <= 1'b1;
      miso_s1_q <= 1'b0;
      miso_s2_q <= 1'b0;
      tgl_s1_q  <= 1'b0;
      tgl_s2_q  <= 1'b0;
      tgl_s3_q  <= 1'b0;
    end else begin
      nss_s1_q  <= nss_in;
      nss_s2_q  <= nss_s1_q;
      nss_s3_q  <= nss_s2_q;
      miso_s1_q <= miso_in;
      miso_s2_q <= miso_s1_q;
      tgl_s1_q  <= lnk.rx_tgl;
      tgl_s2_q  <= tgl_s1_q;
      tgl_s3_q  <= tgl_s2_q;
    end
  end

  // Role and select-mode decode
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_q     <= spisel_pkg::MODE_RST;
      slave_3w_q <= 1'b0;
      slave_4w_q <= 1'b0;
    end else begin
      mode_q     <= select_mode_field_in;
      slave_3w_q <= port_enable_bit_in && !master_mode_in
                    && (select_mode_field_in == spisel_pkg::SEL_3WIRE);
      slave_4w_q <= port_enable_bit_in && !master_mode_in
                    && (select_mode_field_in == spisel_pkg::SEL_4W_SLAVE);
    end
  end

  // Select falling edge while a 4-wire multi-master
  assign nss_fall = nss_s3_q && !nss_s2_q
                    && (mode_q == spisel_pkg::SEL_4W_SLAVE) && master_act_q;

  // Sticky mode fault; a new fault wins over the clear
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fault_q <= 1'b0;
    end else if (nss_fall) begin
      fault_q <= 1'b1;
    end else if (mode_fault_clear_in) begin
      fault_q <= 1'b0;
    end
  end

  // Master function live while enabled, in master role, and no fault
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      master_act_q <= 1'b0;
    end else begin
      master_act_q <= port_enable_bit_in && master_mode_in
                      && !fault_q && !nss_fall;
    end
  end

  // Half period from the rate value, floored at the fastest legal rate
  always_comb begin
    half_cyc = {1'b0, master_clock_rate_register_in} + 9'h001;
    if (half_cyc < spisel_pkg::MIN_HALF_CYC) begin
      half_cyc = spisel_pkg::MIN_HALF_CYC;
    end
  end

  assign tick    = (state_q == spisel_pkg::MST_RUN) && (div_q == half_cyc - 9'h001);
  assign leading = !edge_q[0];

  // Master sequencer
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= spisel_pkg::MST_IDLE;
    end else begin
      case (state_q)
        spisel_pkg::MST_IDLE: begin
          if (master_start_in && master_act_q) begin
            state_q <= spisel_pkg::MST_RUN;
          end
        end
        spisel_pkg::MST_RUN: begin
          if (!master_act_q) begin
            state_q <= spisel_pkg::MST_IDLE; // Aborted by a fault or when the port is disabled
          end else if (tick && (edge_q == spisel_pkg::LAST_EDGE)) begin
            state_q <= spisel_pkg::MST_DONE;
          end
        end
        spisel_pkg::MST_DONE: begin
          state_q <= spisel_pkg::MST_IDLE;
        end
        default: begin
          state_q <= spisel_pkg::MST_IDLE;
        end
      endcase
    end
  end

  // Clock divider and edge counter, used only in the master role
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_q  <= spisel_pkg::DIV_RST;
      edge_q <= spisel_pkg::EDGE_RST;
    end else if (state_q != spisel_pkg::MST_RUN) begin
      div_q  <= spisel_pkg::DIV_RST;
      edge_q <= spisel_pkg::EDGE_RST;
    end else if (tick) begin
      div_q  <= spisel_pkg::DIV_RST;
      edge_q <= edge_q + 4'h1;
    end else begin
      div_q  <= div_q + 9'h001;
    end
  end

  // Serial clock: idles at the polarity level, toggles on each tick
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sck_q <= 1'b0;
    end else if (state_q != spisel_pkg::MST_RUN) begin
      sck_q <= clock_polarity_in;
    end else if (tick) begin
      sck_q <= ~sck_q;
    end
  end

  // Master shift path: sample on one edge kind, shift on the other
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mtx_q <= spisel_pkg::WORD_RST;
      mrx_q <= spisel_pkg::WORD_RST;
    end else if (state_q == spisel_pkg::MST_IDLE) begin
      if (master_start_in && master_act_q) begin
        mtx_q <= master_tx_data_in;
        mrx_q <= spisel_pkg::WORD_RST;
      end
    end else if (tick) begin
      if (leading ^ clock_phase_select_in) begin
        mrx_q <= {mrx_q[6:0], miso_s2_q};
      end else if (edge_q != spisel_pkg::EDGE_RST) begin
        mtx_q <= {mtx_q[6:0], 1'b0};
      end
    end
  end

  // Master results
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mrx_data_q <= spisel_pkg::WORD_RST;
      mdone_q    <= 1'b0;
    end else begin
      mdone_q <= (state_q == spisel_pkg::MST_DONE);
      if (state_q == spisel_pkg::MST_DONE) begin
        mrx_data_q <= mrx_q;
      end
    end
  end

  // Slave transmit word, held until the next load
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stx_q <= spisel_pkg::WORD_RST;
    end else if (slave_tx_load_in) begin
      stx_q <= slave_tx_data_in;
    end
  end

  // Slave receive word taken when the toggle has crossed
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      srx_data_q  <= spisel_pkg::WORD_RST;
      srx_valid_q <= 1'b0;
    end else begin
      srx_valid_q <= tgl_s2_q ^ tgl_s3_q;
      if (tgl_s2_q ^ tgl_s3_q) begin
        srx_data_q <= lnk.rx_word;
      end
    end
  end

  // Pin enables and select output
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mosi_oe_q <= 1'b0;
      miso_oe_q <= 1'b0;
      nss_out_q <= 1'b1;
      nss_oe_q  <= 1'b0;
      nss_map_q <= 1'b0;
    end else begin
      mosi_oe_q <= master_act_q;
      miso_oe_q <= slave_3w_q || (slave_4w_q && !nss_s2_q);
      nss_out_q <= select_mode_field_in[0];
      nss_oe_q  <= port_enable_bit_in && select_mode_field_in[1];
      nss_map_q <= (select_mode_field_in != spisel_pkg::SEL_3WIRE);
    end
  end

  // Link side: selected always in 3-wire, by a low select in 4-wire
  assign lnk.frame_rst_n = rst_n_in
                           && (slave_3w_q || (slave_4w_q && !nss_in));
  assign lnk.sample_rise = ~(clock_polarity_in ^ clock_phase_select_in);
  assign lnk.pha         = clock_phase_select_in;
  assign lnk.tx_word     = stx_q;

  spisel_slave_link u_slave (
    .link_sck_in (link_sck_in),
    .rst_n_in    (rst_n_in),
    .mosi_in     (mosi_in),
    .lnk         (lnk)
  );

  // Outputs
  assign master_rx_data_out = mrx_data_q;
  assign master_done_out    = mdone_q;
  assign master_busy_out    = (state_q != spisel_pkg::MST_IDLE);
  assign mode_fault_out     = fault_q;
  assign slave_rx_data_out  = srx_data_q;
  assign slave_rx_valid_out = srx_valid_q;
  assign sck_out            = sck_q;
  assign sck_oe_out         = master_act_q;
  assign mosi_out           = mtx_q[7];
  assign mosi_oe_out        = mosi_oe_q;
  assign miso_out           = lnk.miso_bit;
  assign miso_oe_out        = miso_oe_q;
  assign nss_out            = nss_out_q;
  assign nss_oe_out         = nss_oe_q;
  assign nss_pin_mapped_out = nss_map_q;

endmodule : spisel_top

`default_nettype wire

//--- core/spisel_pkg.sv
/*
  Constants and types shared by the serial port core and its link-side
  slave engine. Assumes a 100 MHz system clock.
*/
`default_nettype none

package spisel_pkg;

  // Clock figures, in kHz
  localparam int SYS_CLK_KHZ    = 100_000;
  localparam int MAX_MASTER_KHZ = 12_500;

  // Shortest master clock period, rounded up to whole cycles
  localparam int MIN_SCK_PERIOD_CYC =
    (SYS_CLK_KHZ + MAX_MASTER_KHZ - 1) / MAX_MASTER_KHZ;

  // Shortest half period of the master clock
  localparam logic [8:0] MIN_HALF_CYC = 9'(MIN_SCK_PERIOD_CYC / 2);

  // Edges in one 8-bit master transfer, minus one
  localparam logic [3:0] LAST_EDGE = 4'hf;

  // Select-mode encodings
  localparam logic [1:0] SEL_3WIRE    = 2'h0;
  localparam logic [1:0] SEL_4W_SLAVE = 2'h1;

  // Reset values
  localparam logic [7:0] WORD_RST   = 8'h00;
  localparam logic [1:0] MODE_RST   = 2'h0;
  localparam logic [8:0] DIV_RST    = 9'h000;
  localparam logic [2:0] BITCNT_RST = 3'h0;
  localparam logic [3:0] EDGE_RST   = 4'h0;

  // Master sequencer states
  typedef enum logic [1:0] {
    MST_IDLE,
    MST_RUN,
    MST_DONE
  } spisel_mst_state_t;

endpackage : spisel_pkg

`default_nettype wire

//--- core/spisel_link_if.sv
/*
  Signals between the system-clock core and the slave engine that runs
  on the serial clock. Words crossing here are held stable while the
  toggle that announces them is synchronised.
*/
`default_nettype none

interface spisel_link_if;
  logic       frame_rst_n; // Low while the slave is not selected
  logic       sample_rise; // Slave samples on the rising clock edge
  logic       pha;         // Clock phase setting
  logic [7:0] tx_word;     // Next word to send as slave
  logic [7:0] rx_word;     // Last word received as slave
  logic       rx_tgl;      // Flips once per received word
  logic       miso_bit;    // Bit shown on master-in

  modport core (output frame_rst_n, output sample_rise, output pha,
                output tx_word, input rx_word, input rx_tgl, input miso_bit);
  modport link (input frame_rst_n, input sample_rise, input pha,
                input tx_word, output rx_word, output rx_tgl, output miso_bit);
endinterface : spisel_link_if

`default_nettype wire

//--- core/spisel_slave_link.sv
/*
  Slave shift engine, clocked by the serial clock pin. Assumes the clock
  stands still outside frames and that phase and polarity only change
  while the port is disabled.
*/
`default_nettype none

module spisel_slave_link (
  input  wire logic    link_sck_in,
  input  wire logic    rst_n_in,
  input  wire logic    mosi_in,
  spisel_link_if.link  lnk
);

  logic [7:0] rx_q;
  logic [7:0] tx_q;
  logic [2:0] bit_cnt_q;
  logic       loaded_q;
  logic       rx_tgl_q;
  logic [7:0] rx_word_q;
  logic       eng_clk;

  // Engine clock: its rising edge is always the sample edge
  assign eng_clk = link_sck_in ^ ~lnk.sample_rise;

  // Receive shift on the sample edge
  always_ff @(posedge eng_clk or negedge lnk.frame_rst_n) begin
    if (!lnk.frame_rst_n) begin
      rx_q      <= spisel_pkg::WORD_RST;
      bit_cnt_q <= spisel_pkg::BITCNT_RST;
    end else begin
      rx_q      <= {rx_q[6:0], mosi_in};
      bit_cnt_q <= bit_cnt_q + 3'h1;
    end
  end

  // Transmit shift on the opposite edge; first bit placed by phase
  always_ff @(negedge eng_clk or negedge lnk.frame_rst_n) begin
    if (!lnk.frame_rst_n) begin
      tx_q     <= spisel_pkg::WORD_RST;
      loaded_q <= 1'b0;
    end else begin
      loaded_q <= 1'b1;
      if (!loaded_q) begin
        tx_q <= lnk.pha ? lnk.tx_word : {lnk.tx_word[6:0], 1'b0};
      end else if (bit_cnt_q == spisel_pkg::BITCNT_RST) begin
        tx_q <= lnk.tx_word;
      end else begin
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end

  // Word hand-off, kept across frames so the toggle never jumps
  always_ff @(posedge eng_clk or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_word_q <= spisel_pkg::WORD_RST;
      rx_tgl_q  <= 1'b0;
    end else if (lnk.frame_rst_n && (bit_cnt_q == 3'h7)) begin
      rx_word_q <= {rx_q[6:0], mosi_in};
      rx_tgl_q  <= ~rx_tgl_q;
    end
  end

  // Master-in from the shift register MSB, or the word MSB before the first shift
  assign lnk.miso_bit = loaded_q ? tx_q[7] : lnk.tx_word[7];
  assign lnk.rx_word  = rx_word_q;
  assign lnk.rx_tgl   = rx_tgl_q;

endmodule : spisel_slave_link

`default_nettype wire

//--- verif/spisel_asserts.sv
/*
  Checker for the serial port top: pin directions, select modes,
  master clock pacing and mode fault. Assumes it is bound to spisel_top.
*/
`default_nettype none

module spisel_asserts (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       port_enable_bit_in,
  input  wire logic       master_mode_in,
  input  wire logic [1:0] select_mode_field_in,
  input  wire logic       nss_in,
  input  wire logic       mode_fault_out,
  input  wire logic       slave_rx_valid_out,
  input  wire logic       sck_out,
  input  wire logic       sck_oe_out,
  input  wire logic       mosi_oe_out,
  input  wire logic       miso_oe_out,
  input  wire logic       nss_out,
  input  wire logic       nss_oe_out,
  input  wire logic       nss_pin_mapped_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  // Shorthands for the configuration
  wire logic       en  = port_enable_bit_in;
  wire logic       mst = master_mode_in;
  wire logic [1:0] sm  = select_mode_field_in;

  AST_MOSI_MST: assert property (
    (en && mst && sm != 2'h1 && !mode_fault_out)[*3] |-> mosi_oe_out && sck_oe_out)
    else $error("live master does not drive its lines");
  AST_SLV_QUIET: assert property (
    (!mst)[*3] |-> !mosi_oe_out && !sck_oe_out)
    else $error("slave drives master-out or clock");
  AST_MISO_MST: assert property (
    mst[*3] |-> !miso_oe_out)
    else $error("master drives master-in");
  AST_OFF_FLOAT: assert property (
    (!en)[*3] |-> !miso_oe_out && !mosi_oe_out && !sck_oe_out)
    else $error("disabled port drives a line");
  AST_MISO_3W: assert property (
    (en && !mst && sm == 2'h0)[*3] |-> miso_oe_out)
    else $error("three-wire slave not driving master-in");
  AST_UNSEL: assert property (
    (en && !mst && sm == 2'h1 && nss_in)[*8] |-> !miso_oe_out && !slave_rx_valid_out)
    else $error("unselected slave is active");
  AST_NSS_OUT: assert property (
    (en && sm[1])[*3] |-> nss_oe_out && nss_out == sm[0])
    else $error("select output level wrong");
  AST_NSS_IN: assert property (
    (!sm[1])[*3] |-> !nss_oe_out)
    else $error("select driven while it is an input");
  AST_MAPPED: assert property (
    $stable(sm)[*3] |-> nss_pin_mapped_out == (sm != 2'h0))
    else $error("select pin mapping wrong");
  AST_SCK_RATE: assert property (
    sck_oe_out && $past(sck_oe_out) && $changed(sck_out) |=> $stable(sck_out)[*3])
    else $error("master clock half period too short");
  AST_FAULT_SRC: assert property (
    $rose(mode_fault_out) |-> sm == 2'h1 && mst)
    else $error("fault outside multi-master mode");
  AST_FAULT_OFF: assert property (
    mode_fault_out[*2] |-> !sck_oe_out && !mosi_oe_out)
    else $error("faulted master still drives");
endmodule // spisel_asserts

bind spisel_top spisel_asserts spisel_asserts_inst (
  .sys_clk_in, .rst_n_in, .port_enable_bit_in, .master_mode_in,
  .select_mode_field_in, .nss_in, .mode_fault_out, .slave_rx_valid_out,
  .sck_out, .sck_oe_out, .mosi_oe_out, .miso_oe_out, .nss_out,
  .nss_oe_out, .nss_pin_mapped_out);

`default_nettype wire

//--- verif/spisel_partner.sv
/*
  Far-side model: an outside master clocking frames on the link and an
  outside slave answering the port's master clock. Assumes phase 0,
  polarity 0, and bus lines resolved by the bench.
*/
`default_nettype none

module spisel_partner (
  input  wire logic sck_line_in,
  input  wire logic mosi_line_in,
  input  wire logic miso_line_in,
  output logic      p_sck_out,
  output logic      p_mosi_out,
  output logic      p_miso_out,
  output logic      p_nss_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] s_tx_q; // Slave answer word
  logic [7:0] s_rx_q; // Word heard as slave

  // Idle: clock still, select high
  initial begin
    p_sck_out = 1'b0;
    p_mosi_out = 1'b1;
    p_nss_out = 1'b1;
    s_tx_q = 8'h00;
    s_rx_q = 8'h00;
  end

  // Slave role: sample on rise, shift on fall, fill changes each bit
  assign p_miso_out = s_tx_q[7];
  always @(posedge sck_line_in) s_rx_q <= {s_rx_q[6:0], mosi_line_in};
  always @(negedge sck_line_in) s_tx_q <= {s_tx_q[6:0], ~s_tx_q[0]};

  // Select level control
  task sel(input logic v);
    p_nss_out = v;
  endtask

  // Answer word for the next frame
  task preset(input logic [7:0] d);
    s_tx_q = d;
  endtask

  // One frame, MSB first; 40 ns clock pulses with an 80 ns gap, under clock/10
  task xfer(input logic [7:0] d, input logic do_sel, output logic [7:0] r);
    int i;
    #3;
    p_nss_out = ~do_sel;
    #80;
    for (i = 7; i >= 0; i--) begin
      p_mosi_out = d[i];
      #40 p_sck_out = 1'b1;
      r = {r[6:0], miso_line_in};
      #40 p_sck_out = 1'b0;
      #40;
    end
    p_nss_out = 1'b1;
    p_mosi_out = ~d[0];
  endtask
endmodule // spisel_partner

`default_nettype wire

//--- verif/spisel_top_tb.sv
/*
  Self-checking bench for the serial port top: master frames in each
  select mode, slave frames in modes 00 and 01, select handling and mode
  fault. Assumes the partner model sits on the four bus lines.
*/
`default_nettype none

module spisel_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic       sys_clk_in, rst_n_in, port_enable_bit_in, master_mode_in;
  logic [1:0] select_mode_field_in;
  logic       clock_polarity_in, clock_phase_select_in, master_start_in;
  logic [7:0] master_clock_rate_register_in, master_tx_data_in, slave_tx_data_in;
  logic       mode_fault_clear_in, slave_tx_load_in, master_done_out;
  logic [7:0] master_rx_data_out, slave_rx_data_out, rx_got, pr;
  logic       master_busy_out, mode_fault_out, slave_rx_valid_out, sck_out;
  logic       sck_oe_out, mosi_out, mosi_oe_out, miso_out, miso_oe_out;
  logic       nss_out, nss_oe_out, nss_pin_mapped_out, p_sck, p_mosi, p_miso, p_nss;
  wire logic  sck_w, mosi_w, miso_w, nss_w;
  int         fail_count, checks, rx_seen;

  // Bus lines taken from the top where it enables them, else from the partner
  assign sck_w  = sck_oe_out  ? sck_out  : p_sck;
  assign mosi_w = mosi_oe_out ? mosi_out : p_mosi;
  assign miso_w = miso_oe_out ? miso_out : p_miso;
  assign nss_w  = nss_oe_out  ? nss_out  : p_nss;

  spisel_top spisel_top_inst (.sys_clk_in, .rst_n_in, .port_enable_bit_in,
    .master_mode_in, .select_mode_field_in, .clock_polarity_in,
    .clock_phase_select_in, .master_clock_rate_register_in, .master_start_in,
    .master_tx_data_in, .master_rx_data_out, .master_done_out, .master_busy_out,
    .mode_fault_out, .mode_fault_clear_in, .slave_tx_load_in, .slave_tx_data_in,
    .slave_rx_data_out, .slave_rx_valid_out, .link_sck_in(sck_w), .sck_out,
    .sck_oe_out, .mosi_in(mosi_w), .mosi_out, .mosi_oe_out, .miso_in(miso_w),
    .miso_out, .miso_oe_out, .nss_in(nss_w), .nss_out, .nss_oe_out,
    .nss_pin_mapped_out);

  spisel_partner spisel_partner_inst (.sck_line_in(sck_w), .mosi_line_in(mosi_w),
    .miso_line_in(miso_w), .p_sck_out(p_sck), .p_mosi_out(p_mosi),
    .p_miso_out(p_miso), .p_nss_out(p_nss));

  // System clock
  always #5 sys_clk_in = ~sys_clk_in;

  // Catch slave word pulses
  always @(negedge sys_clk_in) if (slave_rx_valid_out === 1'b1) begin
    rx_seen++;
    rx_got = slave_rx_data_out;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Reconfigure only while disabled
  task automatic cfg(input logic m, input logic [1:0] sm, input logic [7:0] r);
    @(negedge sys_clk_in);
    port_enable_bit_in = 1'b0;
    @(negedge sys_clk_in);
    master_mode_in = m;
    select_mode_field_in = sm;
    master_clock_rate_register_in = r;
    @(negedge sys_clk_in);
    port_enable_bit_in = 1'b1;
    repeat (4) @(negedge sys_clk_in);
  endtask

  // Master frame: timing, both data directions, select pin
  task automatic t_master(input logic [1:0] sm, input logic [7:0] r);
    int n;
    int h;
    h = (r + 1 > 4) ? r + 1 : 4;
    cfg(1'b1, sm, r);
    spisel_partner_inst.preset(8'h3c);
    master_tx_data_in = 8'ha5;
    master_start_in = 1'b1;
    @(negedge sys_clk_in);
    master_start_in = 1'b0;
    n = 0;
    while (master_done_out !== 1'b1 && n < 400) begin
      @(negedge sys_clk_in);
      n++;
    end
    chk(8'(n), 8'(1 + 16 * h));
    chk(master_rx_data_out, 8'h3c);
    chk(spisel_partner_inst.s_rx_q, 8'ha5);
    chk({7'h00, nss_pin_mapped_out}, {7'h00, sm != 2'h0});
    if (sm[1]) chk({6'h00, nss_oe_out, nss_out}, {6'h00, 1'b1, sm[0]});
    $display("test master mode %h rate %h done", sm, r);
  endtask

  // Slave frame from the outside master, selected or not
  task automatic t_slave(input logic [1:0] sm, input logic sel);
    logic on;
    on = sel || sm == 2'h0;
    cfg(1'b0, sm, 8'hff);
    slave_tx_data_in = 8'hc3;
    slave_tx_load_in = 1'b1;
    @(negedge sys_clk_in);
    slave_tx_load_in = 1'b0;
    rx_seen = 0;
    spisel_partner_inst.xfer(8'h5a, sel, pr);
    repeat (10) @(negedge sys_clk_in);
    chk(8'(rx_seen), {7'h00, on});
    if (on) chk(rx_got, 8'h5a);
    if (on) chk(pr, 8'hc3);
    chk({7'h00, miso_oe_out}, {7'h00, sm == 2'h0});
    $display("test slave mode %h select %b done", sm, sel);
  endtask

  // Select falls under a live multi-master
  task automatic t_fault;
    int n;
    cfg(1'b1, 2'h1, 8'h00);
    spisel_partner_inst.sel(1'b0);
    n = 0;
    while (mode_fault_out !== 1'b1 && n < 20) begin
      @(negedge sys_clk_in);
      n++;
    end
    repeat (2) @(negedge sys_clk_in);
    chk({6'h00, sck_oe_out, mosi_oe_out}, 8'h00);
    master_start_in = 1'b1;
    @(negedge sys_clk_in);
    master_start_in = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    chk({7'h00, master_busy_out}, 8'h00);
    spisel_partner_inst.sel(1'b1);
    mode_fault_clear_in = 1'b1;
    repeat (4) @(negedge sys_clk_in);
    mode_fault_clear_in = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    chk({6'h00, mode_fault_out, sck_oe_out}, 8'h01);
    $display("test mode fault done");
  endtask

  // Main sequence
  initial begin
    sys_clk_in = 1'b0;
    rst_n_in = 1'b0;
    {port_enable_bit_in, master_mode_in, clock_polarity_in} = 3'h0;
    clock_phase_select_in = 1'b0;
    {master_start_in, mode_fault_clear_in, slave_tx_load_in} = 3'h0;
    select_mode_field_in = 2'h0;
    {master_clock_rate_register_in, master_tx_data_in, slave_tx_data_in} = 24'h00_0000;
    fail_count = 0;
    checks = 0;
    rx_seen = 0;
    repeat (4) @(negedge sys_clk_in);
    chk({4'h0, sck_oe_out, mosi_oe_out, miso_oe_out, nss_out}, 8'h01);
    rst_n_in = 1'b1;
    t_master(2'h0, 8'h09);
    t_master(2'h2, 8'h00);
    t_master(2'h3, 8'h05);
    t_master(2'h1, 8'h00);
    t_slave(2'h0, 1'b0);
    t_slave(2'h1, 1'b1);
    t_slave(2'h1, 1'b0);
    t_fault;
    wrap_up;
  end

  // Watchdog well beyond the expected run
  initial begin
    #300_000;
    fail_count++;
    $display("watchdog expired at %0t", $time);
    wrap_up;
  end
endmodule // spisel_top_tb

`default_nettype wire
